/* File: design/i2c_reg_slave.sv */
/*
 two-wire register slave: pointer, data write, auto-increment read.
 assumes scl and sda synchronised to mclk.
*/
`timescale 1ns/1ps
module i2c_reg_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // synchronised bus levels
    input wire logic scl_s,
    input wire logic scl_p,
    input wire logic sda_s,
    input wire logic sda_p,
    output logic sda_oe_b_q,
    // register side
    output logic [7:0] ptr_q,
    input wire logic [7:0] rd_data,
    output logic wr_q,
    output logic [7:0] wdata_q
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_AACK = 3'b010,
        S_WRITE = 3'b011,
        S_WACK = 3'b100,
        S_READ = 3'b101,
        S_RACK = 3'b110
    } st_e;
    st_e st_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic first_q;
    wire rise = scl_s & ~scl_p;
    wire fall = ~scl_s & scl_p;
    wire start = scl_s & scl_p & sda_p & ~sda_s;
    wire stop = scl_s & scl_p & ~sda_p & sda_s;
    wire full = cnt_q == 4'h8;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= S_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            first_q <= 1'b0;
            ptr_q <= 8'h00;
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
            sda_oe_b_q <= 1'b1;
        end
        else
        begin
            wr_q <= 1'b0;
            if (start)
            begin
                st_q <= S_ADDR;
                cnt_q <= 4'h0;
                sda_oe_b_q <= 1'b1;
            end
            else if (stop)
            begin
                st_q <= S_IDLE;
                sda_oe_b_q <= 1'b1;
            end
            else
            begin
                case (st_q)
                    S_ADDR, S_WRITE:
                    begin
                        if (rise)
                        begin
                            sh_q <= {sh_q[6:0], sda_s};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        else if (fall && full)
                        begin
                            if (st_q == S_ADDR)
                            begin
                                st_q <= (sh_q[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
                                sda_oe_b_q <= sh_q[7:1] != DEV_ADDR;
                            end
                            else
                            begin
                                st_q <= S_WACK;
                                sda_oe_b_q <= 1'b0;
                                if (first_q)
                                    ptr_q <= sh_q;
                                else
                                begin
                                    wr_q <= 1'b1;
                                    wdata_q <= sh_q;
                                end
                            end
                        end
                    end
                    S_AACK, S_WACK, S_RACK:
                    begin
                        if (rise && st_q == S_RACK && sda_s)
                            st_q <= S_IDLE;
                        else if (fall)
                        begin
                            cnt_q <= 4'h0;
                            if (st_q == S_WACK)
                            begin
                                if (!first_q)
                                    ptr_q <= ptr_q + 8'h01;
                                first_q <= 1'b0;
                            end
                            // read path: the address ack of a read, or the master ack of a read byte, has been taken
                            if (st_q == S_RACK || (st_q == S_AACK && sh_q[0]))
                            begin
                                st_q <= S_READ;
                                sh_q <= rd_data;
                                sda_oe_b_q <= rd_data[7];
                                ptr_q <= ptr_q + 8'h01;
                            end
                            else
                            begin
                                st_q <= S_WRITE;
                                sda_oe_b_q <= 1'b1;
                                if (st_q == S_AACK)
                                    first_q <= 1'b1;
                            end
                        end
                    end
                    S_READ:
                    begin
                        if (rise)
                            cnt_q <= cnt_q + 4'h1;
                        else if (fall && full)
                        begin
                            st_q <= S_RACK;
                            sda_oe_b_q <= 1'b1;
                        end
                        else if (fall)
                        begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_b_q <= sh_q[6];
                        end
                    end
                    default:
                        st_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: design/irq_flag_bank.sv */
/*
 eight sticky request flags, cleared by writing zero to a bit.
 assumes set pulses and write strobe on mclk.
*/
`timescale 1ns/1ps
module irq_flag_bank (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // events and host write
    input wire logic [7:0] set_pulse,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // flags
    output logic [7:0] flags_q
);
    logic [7:0] clr;
    logic [7:0] flags_d;

    // a one written leaves the flag alone
    assign clr = wr_en ? ~wr_data : 8'h00;
    // set wins over a clear in the same cycle
    assign flags_d = set_pulse | (flags_q & ~clr);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            flags_q <= 8'h00;
        else
            flags_q <= flags_d;
    end
endmodule

/* File: design/pmic_irq_and_charge_control.sv */
/*
 request flags, fault mask, charger and power-path settings over two-wire.
 assumes events on mclk; scl, sda and general pins asynchronous.
*/
// How it works
// [R01] adc done, analog hi-z, edges on two pins and thermal fault each latch a flag.
// [R02] any change of the charger status bits latches a charger flag.
// [R03] converter input above high limit and below low limit latch separate flags.
// [R04] a latched flag stays until the host writes zero there; one does nothing.
// [R05] mask register at 07, one bit per supply; one excludes its power-good fault.
// [R06] fast-charge current is scaled to 25, 50, 75 or 100 percent.
// [R07] termination threshold is scaled to 25, 50, 75 or 100 percent of nominal.
// [R08] precharge and nominal termination currents are fixed at ten percent of fast charge.
// [R09] charge voltage is 4.2 V or 4.36 V by one host bit.
// [R10] charge current drops to the input limit when that limit is lower.
// [R11] usb input limit is 100 mA, 500 mA or 2.5 A by host selection.
// [R12] adapter input limit is fixed at 2.5 A.
// [R13] automatic source order: adapter, then usb, battery only with neither.
// [R14] host override ties battery to system and ignores the automatic order.
// [R15] after reset: input feeds system, usb mode, 100 mA limit.
// [R16] enable low opens both input switches and feeds system from battery.
`timescale 1ns/1ps
module pmic_irq_and_charge_control #(
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // host two-wire port
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_q,
    output logic sda_oe_b_q,
    // event sources
    input wire logic adc_done,
    input wire logic anlg_hiz,
    input wire logic gpio1_in,
    input wire logic gpio2_in,
    input wire logic thermal_fault,
    input wire logic [3:0] chg_status,
    input wire logic adc_above_hi,
    input wire logic adc_below_lo,
    // supply faults and detectors
    input wire logic [7:0] supply_fault,
    input wire logic ac_det,
    input wire logic usb_det,
    input wire logic supplement_need,
    input wire logic [11:0] fast_full_ma,
    // power path and charger settings
    output logic ac_switch_on_q,
    output logic usb_switch_on_q,
    output logic bat_switch_on_q,
    output logic [1:0] sys_source_q,
    output logic [11:0] in_limit_ma_q,
    output logic [11:0] charge_ma_q,
    output logic [11:0] precharge_ma_q,
    output logic [11:0] term_ma_q,
    output logic [12:0] vreg_mv_q,
    output logic chg_limited_q,
    output logic supply_in_regulation_flag_fault_q
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // quarter steps: code 0..3 gives 25..100 percent
    function automatic logic [11:0] quarter(input logic [11:0] v, input logic [1:0] k);
        logic [13:0] p;
        p = {2'b00, v} * ({12'h000, k} + 14'h0001);
        return p[13:2];
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] scl_m_q, sda_m_q, g1_m_q, g2_m_q;
    logic scl_s_q, sda_s_q, g1_s_q, g2_s_q;
    logic scl_p_q, sda_p_q, g1_p_q, g2_p_q;
    logic [3:0] chg_status_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_m_q <= 2'h3;
            sda_m_q <= 2'h3;
            g1_m_q <= 2'h0;
            g2_m_q <= 2'h0;
            {scl_s_q, sda_s_q, g1_s_q, g2_s_q} <= 4'hC;
            {scl_p_q, sda_p_q, g1_p_q, g2_p_q} <= 4'hC;
            chg_status_q <= 4'h0;
            sda_out_q <= 1'b0;
        end
        else
        begin
            scl_m_q <= {scl_m_q[0], scl_in};
            sda_m_q <= {sda_m_q[0], sda_in};
            g1_m_q <= {g1_m_q[0], gpio1_in};
            g2_m_q <= {g2_m_q[0], gpio2_in};
            {scl_s_q, sda_s_q, g1_s_q, g2_s_q} <= {scl_m_q[1], sda_m_q[1], g1_m_q[1], g2_m_q[1]};
            {scl_p_q, sda_p_q, g1_p_q, g2_p_q} <= {scl_s_q, sda_s_q, g1_s_q, g2_s_q};
            chg_status_q <= chg_status;
            sda_out_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // host port
    // ----------------------------------------
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rd_data;
    i2c_reg_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
        .mclk(mclk),
        .rst_b(rst_b),
        .scl_s(scl_s_q),
        .scl_p(scl_p_q),
        .sda_s(sda_s_q),
        .sda_p(sda_p_q),
        .sda_oe_b_q(sda_oe_b_q),
        .ptr_q(ptr),
        .rd_data(rd_data),
        .wr_q(wr),
        .wdata_q(wdata)
    );

    // ----------------------------------------
    // request flags
    // ----------------------------------------
    logic [7:0] irq_set;
    logic [7:0] irq_flags;
    assign irq_set[pmic_pkg::IRQ_ADC_DONE] = adc_done; // [R01]
    assign irq_set[pmic_pkg::IRQ_ANLG_HIZ] = anlg_hiz; // [R01]
    assign irq_set[pmic_pkg::IRQ_GPIO2] = g2_s_q ^ g2_p_q; // [R01]
    assign irq_set[pmic_pkg::IRQ_GPIO1] = g1_s_q ^ g1_p_q; // [R01]
    assign irq_set[pmic_pkg::IRQ_THERMAL] = thermal_fault; // [R01]
    assign irq_set[pmic_pkg::IRQ_CHARGER] = chg_status != chg_status_q; // [R02]
    assign irq_set[pmic_pkg::IRQ_ADC_HI] = adc_above_hi; // [R03]
    assign irq_set[pmic_pkg::IRQ_ADC_LO] = adc_below_lo; // [R03]
    wire wr_irq = wr && ptr == pmic_pkg::OFS_IRQ2;
    irq_flag_bank u_flags (
        .mclk(mclk),
        .rst_b(rst_b),
        .set_pulse(irq_set),
        .wr_en(wr_irq), // [R04]
        .wr_data(wdata),
        .flags_q(irq_flags)
    );

    // ----------------------------------------
    // host registers
    // ----------------------------------------
    logic [7:0] power_good_fault_mask_q;
    logic [7:0] charger_configuration_register_q;
    logic [1:0] usb_ilim_sel_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_good_fault_mask_q <= pmic_pkg::RST_PG_MASK;
            charger_configuration_register_q <= pmic_pkg::RST_CHG_CFG; // [R15]
            usb_ilim_sel_q <= pmic_pkg::RST_ILIM; // [R15]
        end
        else if (wr)
        begin
            if (ptr == pmic_pkg::OFS_PG_MASK)
                power_good_fault_mask_q <= wdata; // [R05]
            if (ptr == pmic_pkg::OFS_CHG_CFG)
                charger_configuration_register_q <= {1'b0, wdata[6:0]};
            if (ptr == pmic_pkg::OFS_ILIM)
                usb_ilim_sel_q <= wdata[1:0];
        end
    end
    wire ce = charger_configuration_register_q[pmic_pkg::CFG_CE];
    wire bat_ovr = charger_configuration_register_q[pmic_pkg::CFG_BAT_OVR];
    wire [1:0] chg_scl = charger_configuration_register_q[pmic_pkg::CFG_CHG_SCL +: 2];
    wire [1:0] term_scl = charger_configuration_register_q[pmic_pkg::CFG_TERM_SCL +: 2];
    wire vsel = charger_configuration_register_q[pmic_pkg::CFG_VSEL];

    // ----------------------------------------
    // power path
    // ----------------------------------------
    wire force_batt = !ce || bat_ovr; // [R14] [R16]
    wire use_ac = !force_batt && ac_det; // [R13]
    wire use_usb = !force_batt && !ac_det && usb_det; // [R13]
    wire on_batt = !use_ac && !use_usb;
    wire [1:0] src = use_ac ? pmic_pkg::SRC_AC : (use_usb ? pmic_pkg::SRC_USB : pmic_pkg::SRC_BATT);
    wire [11:0] usb_lim = (usb_ilim_sel_q == pmic_pkg::ILIM_SEL_100) ? pmic_pkg::ILIM_USB_LOW_MA
        : (usb_ilim_sel_q == pmic_pkg::ILIM_SEL_500) ? pmic_pkg::ILIM_USB_HIGH_MA
        : pmic_pkg::ILIM_AC_MA; // [R11]
    // adapter limit is a fixed constant with no register behind it
    wire [11:0] in_lim = use_ac ? pmic_pkg::ILIM_AC_MA : usb_lim; // [R12]
    wire [11:0] fast_ma = quarter(fast_full_ma, chg_scl); // [R06]
    wire [11:0] tenth = 12'(fast_ma / {8'h00, pmic_pkg::PRE_TERM_DIV}); // [R08]
    wire limited = !on_batt && in_lim < fast_ma; // [R10]
    wire [11:0] chg_ma = on_batt ? 12'h000 : (limited ? in_lim : fast_ma);
    wire fault = |(supply_fault & ~power_good_fault_mask_q); // [R05]

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ac_switch_on_q <= 1'b0;
            usb_switch_on_q <= 1'b0;
            bat_switch_on_q <= 1'b1;
            sys_source_q <= pmic_pkg::SRC_BATT;
            in_limit_ma_q <= pmic_pkg::ILIM_USB_LOW_MA;
            charge_ma_q <= 12'h000;
            precharge_ma_q <= 12'h000;
            term_ma_q <= 12'h000;
            vreg_mv_q <= pmic_pkg::VREG_LOW_MV;
            chg_limited_q <= 1'b0;
            supply_in_regulation_flag_fault_q <= 1'b0;
        end
        else
        begin
            ac_switch_on_q <= use_ac; // [R13] [R16]
            usb_switch_on_q <= use_usb; // [R13] [R16]
            // battery joins when forced, alone, or when the bus sags below it
            bat_switch_on_q <= on_batt || supplement_need; // [R14]
            sys_source_q <= src;
            in_limit_ma_q <= in_lim;
            charge_ma_q <= chg_ma; // [R10]
            precharge_ma_q <= tenth; // [R08]
            term_ma_q <= quarter(tenth, term_scl); // [R07]
            vreg_mv_q <= vsel ? pmic_pkg::VREG_HIGH_MV : pmic_pkg::VREG_LOW_MV; // [R09]
            chg_limited_q <= limited;
            supply_in_regulation_flag_fault_q <= fault;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [7:0] stat = {1'b0, supply_in_regulation_flag_fault_q, chg_limited_q, bat_switch_on_q,
        usb_switch_on_q, ac_switch_on_q, sys_source_q};
    assign rd_data = (ptr == pmic_pkg::OFS_IRQ2) ? irq_flags
        : (ptr == pmic_pkg::OFS_PG_MASK) ? power_good_fault_mask_q
        : (ptr == pmic_pkg::OFS_CHG_CFG) ? charger_configuration_register_q
        : (ptr == pmic_pkg::OFS_ILIM) ? {6'h00, usb_ilim_sel_q}
        : (ptr == pmic_pkg::OFS_PATH_STAT) ? stat : 8'h00;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_b) // [R04]
        irq_flags[pmic_pkg::IRQ_THERMAL] && !(wr_irq && !wdata[pmic_pkg::IRQ_THERMAL])
        |=> irq_flags[pmic_pkg::IRQ_THERMAL]) else $error("flag lost without clear");
    chk_flag_set: assert property (@(posedge mclk) disable iff (!rst_b) // [R01]
        adc_done |=> irq_flags[pmic_pkg::IRQ_ADC_DONE]) else $error("adc flag not set");
    chk_charger_flag: assert property (@(posedge mclk) disable iff (!rst_b) // [R02]
        chg_status != $past(chg_status) |=> irq_flags[pmic_pkg::IRQ_CHARGER])
        else $error("charger flag missed");
    chk_limit_flags: assert property (@(posedge mclk) disable iff (!rst_b) // [R03]
        adc_below_lo && !adc_above_hi |=> irq_flags[pmic_pkg::IRQ_ADC_LO])
        else $error("low limit flag missed");
    chk_mask_fault: assert property (@(posedge mclk) disable iff (!rst_b) // [R05]
        (supply_fault & ~power_good_fault_mask_q) == 8'h00 |=> !supply_in_regulation_flag_fault_q)
        else $error("masked fault reported");
    chk_ce_low: assert property (@(posedge mclk) disable iff (!rst_b) // [R16]
        !ce |=> bat_switch_on_q && !ac_switch_on_q && !usb_switch_on_q)
        else $error("enable low not on battery");
    chk_ac_first: assert property (@(posedge mclk) disable iff (!rst_b) // [R13]
        ce && !bat_ovr && ac_det |=> sys_source_q == pmic_pkg::SRC_AC && !usb_switch_on_q)
        else $error("adapter not preferred");
    chk_input_limit: assert property (@(posedge mclk) disable iff (!rst_b) // [R10]
        !on_batt |=> charge_ma_q <= in_limit_ma_q) else $error("charge above input limit");
    chk_ovr_batt: assert property (@(posedge mclk) disable iff (!rst_b) // [R14]
        bat_ovr ##1 bat_ovr |-> sys_source_q == pmic_pkg::SRC_BATT)
        else $error("override ignored");
endmodule

/* File: design/pmic_pkg.sv */
/*
 register map, fields and constants of the charger and mask bank.
 assumes one mclk domain; used by pmic_irq_and_charge_control and the bench, not by the slave or flag bank.
*/
package pmic_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_IRQ2 = 8'h06;
    localparam logic [7:0] OFS_PG_MASK = 8'h07;
    localparam logic [7:0] OFS_CHG_CFG = 8'h08;
    localparam logic [7:0] OFS_ILIM = 8'h09;
    localparam logic [7:0] OFS_PATH_STAT = 8'h0A;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_PG_MASK = 8'h00;
    localparam logic [7:0] RST_CHG_CFG = 8'h3D;
    localparam logic [1:0] RST_ILIM = 2'h0;
    // ----------------------------------------
    // fields of the charger configuration register
    // ----------------------------------------
    localparam int CFG_CE = 0;
    localparam int CFG_BAT_OVR = 1;
    localparam int CFG_CHG_SCL = 2;
    localparam int CFG_TERM_SCL = 4;
    localparam int CFG_VSEL = 6;
    // ----------------------------------------
    // bits of the second request bank
    // ----------------------------------------
    localparam int IRQ_ADC_DONE = 7;
    localparam int IRQ_ANLG_HIZ = 6;
    localparam int IRQ_GPIO2 = 5;
    localparam int IRQ_GPIO1 = 4;
    localparam int IRQ_THERMAL = 3;
    localparam int IRQ_CHARGER = 2;
    localparam int IRQ_ADC_HI = 1;
    localparam int IRQ_ADC_LO = 0;
    // ----------------------------------------
    // currents in mA, voltages in mV
    // ----------------------------------------
    localparam logic [11:0] ILIM_USB_LOW_MA = 12'h064;
    localparam logic [11:0] ILIM_USB_HIGH_MA = 12'h1F4;
    localparam logic [11:0] ILIM_AC_MA = 12'h9C4;
    localparam logic [3:0] PRE_TERM_DIV = 4'hA;
    localparam logic [12:0] VREG_LOW_MV = 13'h1068;
    localparam logic [12:0] VREG_HIGH_MV = 13'h1108;
    localparam logic [1:0] ILIM_SEL_100 = 2'h0;
    localparam logic [1:0] ILIM_SEL_500 = 2'h1;
    // ----------------------------------------
    // system source
    // ----------------------------------------
    typedef enum logic [1:0] {
        SRC_BATT = 2'b00,
        SRC_AC = 2'b01,
        SRC_USB = 2'b10
    } src_e;
endpackage

/* File: verif/i2c_host_model.sv */
/*
 two-wire host: start, stop, register write and read.
 assumes sda_line is the pulled-up wired level.
*/
`timescale 1ns/1ps
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    // clock and wire
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl_o,
    output logic sda_o,
    // read results
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output int nacks
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rd_valid = 1'b0;
        nacks = 0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // long setup: the slave's answer lags its sync chain by several cycles
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--)
        begin
            sda_o = o[k];
            tick(7);
            scl_o = 1'b1;
            tick(3);
            i[k] = sda_line;
            tick(3);
            scl_o = 1'b0;
            tick(1);
        end
    endtask
    task automatic start();
        sda_o = 1'b1;
        tick(8);
        scl_o = 1'b1;
        tick(5);
        sda_o = 1'b0;
        tick(5);
        scl_o = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        tick(3);
        scl_o = 1'b1;
        tick(5);
        sda_o = 1'b1;
        tick(5);
    endtask
    task automatic wr_byte(input logic [7:0] d);
        logic [8:0] i;
        xfer({d, 1'b1}, i);
        if (i[0] !== 1'b0)
            nacks++;
    endtask
    // flags are cleared by writing zero at their positions
    task automatic write_reg(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d);
        start();
        wr_byte({a, 1'b0});
        wr_byte(ofs);
        wr_byte(d);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] ofs);
        logic [8:0] i;
        start();
        wr_byte({DEV_ADDR, 1'b0});
        wr_byte(ofs);
        start();
        wr_byte({DEV_ADDR, 1'b1});
        xfer(9'h1FF, i);
        rd_byte = i[8:1];
        rd_valid = 1'b1;
        tick(1);
        rd_valid = 1'b0;
        stop();
    endtask
endmodule

/* File: verif/tb_pmic_irq_and_charge_control.sv */
/*
 bench: host model on the two-wire port, events driven here.
 assumes a pull-up on sda.
*/
`timescale 1ns/1ps
module tb_pmic_irq_and_charge_control;
    logic mclk = 1'b0, rst_b = 1'b0, sda_out_q, sda_oe_b_q, scl, sda_m, rd_valid;
    logic adc_done = 1'b0, anlg_hiz = 1'b0, gpio1_in = 1'b0, gpio2_in = 1'b0, thermal_fault = 1'b0;
    logic adc_above_hi = 1'b0, adc_below_lo = 1'b0, ac_sw, usb_sw, bat_sw, chg_lim, pg_fault;
    logic ac_det = 1'b0, usb_det = 1'b1, supplement_need = 1'b0;
    logic [3:0] chg_status = 4'h0;
    logic [7:0] supply_fault = 8'h00, rd_byte;
    logic [7:0] expq[$];
    logic [1:0] src;
    logic [11:0] fast_full_ma = 12'h4B0, in_lim, chg_ma, pre_ma, term_ma;
    logic [12:0] vreg;
    logic [31:0] seed = 32'h49;
    int errors = 0, n_compared = 0, nacks, cyc = 0, f;
    wire sda_w = sda_m & sda_oe_b_q;
    always #2 mclk = ~mclk;
    pmic_irq_and_charge_control DUT (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
        .sda_out_q(sda_out_q), .sda_oe_b_q(sda_oe_b_q), .adc_done(adc_done), .anlg_hiz(anlg_hiz),
        .gpio1_in(gpio1_in), .gpio2_in(gpio2_in), .thermal_fault(thermal_fault), .chg_status(chg_status),
        .adc_above_hi(adc_above_hi), .adc_below_lo(adc_below_lo), .supply_fault(supply_fault),
        .ac_det(ac_det), .usb_det(usb_det), .supplement_need(supplement_need), .fast_full_ma(fast_full_ma),
        .ac_switch_on_q(ac_sw), .usb_switch_on_q(usb_sw), .bat_switch_on_q(bat_sw), .sys_source_q(src),
        .in_limit_ma_q(in_lim), .charge_ma_q(chg_ma), .precharge_ma_q(pre_ma), .term_ma_q(term_ma),
        .vreg_mv_q(vreg), .chg_limited_q(chg_lim), .supply_in_regulation_flag_fault_q(pg_fault));
    i2c_host_model HOST (.mclk(mclk), .sda_line(sda_w), .scl_o(scl), .sda_o(sda_m),
        .rd_valid(rd_valid), .rd_byte(rd_byte), .nacks(nacks));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input string what, input logic [12:0] exp, input logic [12:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        expq.push_back(exp);
        HOST.read_reg(ofs);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        HOST.write_reg(7'h48, ofs, d);
    endtask
    // ----------------------------------------
    // result watcher and hang guard
    // ----------------------------------------
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc > 90000)
        begin
            errors++;
            conclude();
        end
        if (rd_valid === 1'b1)
            check("read", 13'(expq.pop_front()), 13'(rd_byte));
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        wt(2);
        rst_b = 1'b1;
        wt(5);
        check("reset_lim", 13'h0064, 13'(in_lim));
        check("reset_src", 13'(pmic_pkg::SRC_USB), 13'(src));
        rd(pmic_pkg::OFS_CHG_CFG, pmic_pkg::RST_CHG_CFG);
        rd(pmic_pkg::OFS_ILIM, 8'h00);
        rd(pmic_pkg::OFS_PG_MASK, pmic_pkg::RST_PG_MASK);
        rd(8'h0F, 8'h00);
        HOST.write_reg(7'h21, pmic_pkg::OFS_PG_MASK, 8'hFF);
        wr(pmic_pkg::OFS_PG_MASK, 8'h5A);
        rd(pmic_pkg::OFS_PG_MASK, 8'h5A);
        repeat (6)
        begin
            seed = xs(seed);
            supply_fault = seed[7:0];
            wt(3);
            check("supply_in_regulation_flag", 13'(|(seed[7:0] & 8'hA5)), 13'(pg_fault));
        end
        {adc_done, anlg_hiz, thermal_fault, adc_above_hi, adc_below_lo} = 5'h1F;
        {gpio1_in, gpio2_in, chg_status} = 6'h35;
        wt(1);
        {adc_done, anlg_hiz, thermal_fault, adc_above_hi, adc_below_lo} = 5'h00;
        wt(6);
        rd(pmic_pkg::OFS_IRQ2, 8'hFF);
        wr(pmic_pkg::OFS_IRQ2, 8'hFF);
        rd(pmic_pkg::OFS_IRQ2, 8'hFF);
        wr(pmic_pkg::OFS_IRQ2, 8'h0F);
        rd(pmic_pkg::OFS_IRQ2, 8'h0F);
        gpio1_in = 1'b0;
        wt(6);
        rd(pmic_pkg::OFS_IRQ2, 8'h1F);
        for (int m = 0; m < 4; m++)
        begin
            {ac_det, usb_det} = m[1:0];
            wt(4);
            check("src", 13'(m[1] ? pmic_pkg::SRC_AC : m[0] ? pmic_pkg::SRC_USB : pmic_pkg::SRC_BATT), 13'(src));
            check("sw", 13'({m[1], m == 1}), 13'({ac_sw, usb_sw}));
        end
        for (int s = 0; s < 4; s++)
        begin
            wr(pmic_pkg::OFS_ILIM, 8'(s));
            {ac_det, usb_det} = 2'b01;
            wt(4);
            check("usb_lim", 13'(s == 0 ? 12'h064 : s == 1 ? 12'h1F4 : 12'h9C4), 13'(in_lim));
            ac_det = 1'b1;
            wt(4);
            check("ac_lim", 13'h09C4, 13'(in_lim));
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(pmic_pkg::OFS_CHG_CFG, {1'b0, k[0], k[1:0], k[1:0], 2'b01});
            wt(4);
            f = 1200 * (k + 1) / 4;
            check("charge", 13'(f), 13'(chg_ma));
            check("pre", 13'(f / 10), 13'(pre_ma));
            check("term", 13'((f / 10) * (k + 1) / 4), 13'(term_ma));
            check("vreg", k[0] ? 13'h1108 : 13'h1068, vreg);
        end
        {ac_det, usb_det} = 2'b01;
        wr(pmic_pkg::OFS_ILIM, 8'h00);
        wt(4);
        check("limited", 13'h0064, 13'(chg_ma));
        check("lim_flag", 13'h0001, 13'(chg_lim));
        ac_det = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            wr(pmic_pkg::OFS_CHG_CFG, i ? 8'h3C : 8'h3F);
            wt(4);
            check("ovr_src", 13'(pmic_pkg::SRC_BATT), 13'(src));
            check("ovr_sw", 13'h0001, 13'({ac_sw, usb_sw, bat_sw}));
        end
        check("nacks", 13'h0003, 13'(nacks));
        conclude();
    end
endmodule
